/* switch_readout_pkg.sv */
package switch_readout_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [7:0] IDX_IND_CTRL   = 8'h6e;  // 110, selection code
    localparam logic [7:0] IDX_IND_ADDR   = 8'h6f;  // 111, index low byte, starts a read
    localparam logic [7:0] IDX_DATA_FIRST = 8'h70;  // 112, bits 71-64
    localparam logic [7:0] IDX_DATA_LAST  = 8'h78;  // 120, bits 7-0
    localparam logic [7:0] IDX_CFG        = 8'h80;  // Frame size settings
    localparam logic [7:0] IDX_STATUS     = 8'h81;  // Read pending flags

    // Selection codes written to the control register
    localparam logic [5:0] SEL_TABLE_READ = 6'h06;  // 0x18..0x1b, low bits are index 9:8
    localparam logic [7:0] SEL_STATS_READ = 8'h1c;

    // Learned table geometry
    localparam int          TABLE_DEPTH = 1024;
    localparam int          IDX_W       = 10;
    localparam int          MAC_W       = 48;
    localparam int          FID_W       = 7;
    localparam int          ENTRY_W     = 61;   // valid, age, port, group id, address
    localparam int          COUNT_W     = 11;

    // Snapshot field positions
    localparam int          SNAP_W       = 72;
    localparam int          POS_EMPTY    = 71;
    localparam int          POS_CNT_LO   = 61;
    localparam int          POS_AGE_LO   = 59;
    localparam int          POS_PORT_LO  = 56;
    localparam int          POS_NOT_RDY  = 55;
    localparam int          POS_FID_LO   = 48;
    localparam int          POS_OVERFLOW = 31;
    localparam int          POS_VALID    = 30;

    // Statistics layout
    localparam int          NUM_PORTS    = 5;
    localparam int          NUM_STATS    = 25;   // offsets 0x0..0x18 per port
    localparam int          CTR_W        = 30;
    localparam int          NUM_CTRS     = NUM_PORTS * NUM_STATS;
    localparam logic [2:0]  PORT_SHIFT   = 3'd5; // 0x20 per port block
    localparam logic [4:0]  STAT_LAST    = 5'h18;

    // Counter offsets within a port block
    localparam int OFS_RX_LO_OCT   = 'h0;
    localparam int OFS_RX_HI_OCT   = 'h1;
    localparam int OFS_RX_SHORT_G  = 'h2;
    localparam int OFS_RX_SHORT_B  = 'h3;
    localparam int OFS_RX_LONG_G   = 'h4;
    localparam int OFS_RX_LONG_B   = 'h5;
    localparam int OFS_RX_SYMBOL   = 'h6;
    localparam int OFS_RX_CHECKSUM = 'h7;
    localparam int OFS_RX_MISALIGN = 'h8;
    localparam int OFS_RX_CONTROL  = 'h9;
    localparam int OFS_RX_PAUSE    = 'ha;
    localparam int OFS_RX_BCAST    = 'hb;
    localparam int OFS_RX_MCAST    = 'hc;
    localparam int OFS_RX_UCAST    = 'hd;
    localparam int OFS_RX_BIN_MIN  = 'he;   // Six histogram bins follow
    localparam int OFS_TX_LO_OCT   = 'h14;
    localparam int OFS_TX_HI_OCT   = 'h15;
    localparam int OFS_TX_LATE     = 'h16;
    localparam int OFS_TX_PAUSE    = 'h17;
    localparam int OFS_TX_BCAST    = 'h18;

    // Frame length limits in bytes
    localparam logic [10:0] LEN_MIN     = 11'd64;
    localparam logic [10:0] LEN_BIN1    = 11'd127;
    localparam logic [10:0] LEN_BIN2    = 11'd255;
    localparam logic [10:0] LEN_BIN3    = 11'd511;
    localparam logic [10:0] LEN_BIN4    = 11'd1023;
    localparam logic [10:0] LEN_MAX_STD = 11'd1522;
    localparam logic [10:0] LEN_MAX_BIG = 11'd1536;
    localparam logic [10:0] LEN_JABBER  = 11'd1916;

    // Configuration bits and reset values
    localparam int          CFG_BIG_MAX   = 0;
    localparam int          CFG_JAB_LONG  = 1;
    localparam logic [1:0]  CFG_RESET     = 2'h0;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;

endpackage : switch_readout_pkg

/* switch_table_and_stats_readout.sv */
`timescale 1ns/1ns

// Operation
// - Learned table changed only by learning side
// - Bit 71 shows table empty, resets 1
// - Bits 70-61 hold valid count minus one
// - Bits 60-59 show entry aging counter
// - Bits 58-56 show learning port code
// - Bit 55 high until entry snapshot ready
// - Select code then index write starts read
// - Index 10 bits, top two in select
// - Snapshot laid out MSB first, regs 112-120
// - Offsets 0x0/0x1 count received octets
// - Offsets 0x2/0x3 count short frames
// - Offset 0x4 counts long good frames
// - Offset 0x5 counts jabber frames
// - Offset 0x6 counts bad symbol frames
// - Offsets 0x7/0x8 count checksum failures
// - Offsets 0x9/0xA count control, pause frames
// - Offsets 0xB-0xD count good cast types
// - Offsets 0xE-0x13 form length histogram
// - Offsets 0x14/0x15 count transmitted octets
// - Offset 0x16 counts late collisions
// - Offsets 0x17/0x18 count pause, broadcast sent
// - Each port owns 0x20 offset block
// - Select code 0x1c then offset write
// - Counter bit 31 overflow, bit 30 valid
// - Counter clears when host reads it
module switch_table_and_stats_readout
    import switch_readout_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Wishbone classic slave
    input  wire logic [9:0]         adr_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    input  wire logic               we_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    output logic                    ack_o,
    // Learning engine side
    input  wire logic               learn_we_i,
    input  wire logic               learn_del_i,
    input  wire logic [IDX_W-1:0]   learn_index_i,
    input  wire logic [MAC_W-1:0]   learn_mac_i,
    input  wire logic [FID_W-1:0]   filter_group_id_i,
    input  wire logic [2:0]         learn_port_i,
    input  wire logic [1:0]         learn_age_i,
    // Receive frame summary, one pulse per frame end
    input  wire logic               rx_done_i,
    input  wire logic [2:0]         rx_port_i,
    input  wire logic [10:0]        rx_len_i,
    input  wire logic               rx_high_prio_i,
    input  wire logic               rx_crc_ok_i,
    input  wire logic               rx_symbol_err_i,
    input  wire logic               rx_odd_bits_i,
    input  wire logic               rx_bcast_i,
    input  wire logic               rx_mcast_i,
    input  wire logic               rx_ctrl_type_i,
    input  wire logic               rx_pause_fields_i,
    // Transmit frame summary
    input  wire logic               tx_done_i,
    input  wire logic [2:0]         tx_port_i,
    input  wire logic [10:0]        tx_len_i,
    input  wire logic               tx_high_prio_i,
    input  wire logic               tx_good_i,
    input  wire logic               tx_pause_i,
    input  wire logic               tx_bcast_i,
    input  wire logic               tx_late_collide_i,
    // Learned table occupancy
    output logic      [COUNT_W-1:0] table_count_o
);

    typedef logic [ENTRY_W-1:0] entry_t;

    typedef struct packed {
        logic                             ack;
        logic [31:0]                      rdata;
        logic [7:0]                       sel_code;
        logic [7:0]                       idx_lo;
        logic [1:0]                       cfg;
        logic                             tbl_stage1;
        logic                             tbl_stage2;
        logic                             tbl_pending;
        logic                             mib_pending;
        logic [IDX_W-1:0]                 tbl_addr;
        logic [7:0]                       mib_addr;
        logic [SNAP_W-1:0]                snap;
        logic [TABLE_DEPTH-1:0]           valid_vec;
        logic [COUNT_W-1:0]               count;
        logic [NUM_CTRS-1:0][CTR_W:0]     ctr;   // Overflow bit on top
    } state_t;

    state_t                 s;
    state_t                 next_s;
    entry_t                 table_mem [TABLE_DEPTH];
    entry_t                 table_q;
    logic [NUM_STATS-1:0]   rx_inc;
    logic [NUM_STATS-1:0]   tx_inc;
    logic [10:0]            max_len;
    logic                   rx_short;
    logic                   rx_long;
    logic                   rx_bad;
    logic                   rx_good;
    logic                   rx_in_range;
    logic                   bus_req;
    logic                   wr_take;
    logic [7:0]             wr_idx;
    logic [7:0]             rd_idx;
    logic [7:0]             rd_byte;
    logic [SNAP_W-1:0]      view;
    logic [2:0]             mib_port;
    logic [4:0]             mib_ofs;
    logic                   mib_hit;
    int                     mib_sel;
    logic [COUNT_W-1:0]     cnt_minus1;

    // Table storage; only the learning engine writes it, the bus never does
    always_ff @(posedge clk_i) begin
        if (learn_we_i) begin
            table_mem[learn_index_i] <= {1'b1, learn_age_i, learn_port_i,
                                         filter_group_id_i, learn_mac_i};
        end else if (learn_del_i) begin
            table_mem[learn_index_i] <= '0;
        end
        table_q <= table_mem[s.tbl_addr];
    end

    // Frame classification against the configured size limit
    always_comb begin
        max_len     = s.cfg[CFG_BIG_MAX] ? LEN_MAX_BIG : LEN_MAX_STD;
        rx_short    = rx_len_i < LEN_MIN;
        rx_long     = rx_len_i > max_len;
        rx_bad      = !rx_crc_ok_i || rx_symbol_err_i || rx_odd_bits_i;
        rx_good     = !rx_bad && !rx_short && !rx_long;
        rx_in_range = !rx_short && !rx_long;
        rx_inc      = '0;
        tx_inc      = '0;
        if (rx_done_i) begin
            rx_inc[OFS_RX_LO_OCT]   = !rx_high_prio_i;
            rx_inc[OFS_RX_HI_OCT]   = rx_high_prio_i;
            rx_inc[OFS_RX_SHORT_G]  = rx_short && !rx_bad;
            rx_inc[OFS_RX_SHORT_B]  = rx_short && rx_bad;
            rx_inc[OFS_RX_LONG_G]   = rx_long && !rx_bad;
            // Jabber rule follows the CFG_JAB_LONG setting
            rx_inc[OFS_RX_LONG_B]   = s.cfg[CFG_JAB_LONG] ? (rx_len_i > LEN_JABBER)
                                                          : (rx_long && rx_bad);
            rx_inc[OFS_RX_SYMBOL]   = rx_in_range && rx_symbol_err_i;
            rx_inc[OFS_RX_CHECKSUM] = rx_in_range && !rx_symbol_err_i && !rx_crc_ok_i
                                      && !rx_odd_bits_i;
            rx_inc[OFS_RX_MISALIGN] = rx_in_range && !rx_symbol_err_i && !rx_crc_ok_i
                                      && rx_odd_bits_i;
            rx_inc[OFS_RX_CONTROL]  = rx_ctrl_type_i;
            rx_inc[OFS_RX_PAUSE]    = rx_ctrl_type_i && rx_pause_fields_i && !rx_short
                                      && !rx_bad;
            rx_inc[OFS_RX_BCAST]    = rx_good && rx_bcast_i;
            rx_inc[OFS_RX_MCAST]    = rx_good && rx_mcast_i && !rx_bcast_i
                                      && !rx_ctrl_type_i;
            rx_inc[OFS_RX_UCAST]    = rx_good && !rx_mcast_i && !rx_bcast_i;
            // Histogram counts bad frames too
            rx_inc[OFS_RX_BIN_MIN]     = rx_len_i == LEN_MIN;
            rx_inc[OFS_RX_BIN_MIN + 1] = rx_len_i > LEN_MIN && rx_len_i <= LEN_BIN1;
            rx_inc[OFS_RX_BIN_MIN + 2] = rx_len_i > LEN_BIN1 && rx_len_i <= LEN_BIN2;
            rx_inc[OFS_RX_BIN_MIN + 3] = rx_len_i > LEN_BIN2 && rx_len_i <= LEN_BIN3;
            rx_inc[OFS_RX_BIN_MIN + 4] = rx_len_i > LEN_BIN3 && rx_len_i <= LEN_BIN4;
            rx_inc[OFS_RX_BIN_MIN + 5] = rx_len_i > LEN_BIN4 && !rx_long;
        end
        if (tx_done_i) begin
            tx_inc[OFS_TX_LO_OCT] = tx_good_i && !tx_high_prio_i;
            tx_inc[OFS_TX_HI_OCT] = tx_good_i && tx_high_prio_i;
            tx_inc[OFS_TX_PAUSE]  = tx_pause_i;
            tx_inc[OFS_TX_BCAST]  = tx_good_i && tx_bcast_i;
        end
        tx_inc[OFS_TX_LATE] = tx_late_collide_i;
    end

    // Bus decode and the data view the host sees
    always_comb begin
        bus_req    = cyc_i && stb_i;
        wr_take    = bus_req && we_i && s.ack && sel_i[0];
        wr_idx     = adr_i[9:2];
        rd_idx     = adr_i[9:2];
        mib_port   = 3'(s.mib_addr >> PORT_SHIFT);
        mib_ofs    = s.mib_addr[4:0];
        mib_hit    = (mib_port < 3'(NUM_PORTS)) && (mib_ofs <= STAT_LAST);
        mib_sel    = int'(mib_port) * NUM_STATS + int'(mib_ofs);
        cnt_minus1 = (s.count == '0) ? '0 : s.count - 1'b1;
        view       = s.snap;
        // Pending flags override the stale snapshot bits
        if (s.tbl_pending) begin
            view[POS_NOT_RDY] = 1'b1;
        end
        if (s.mib_pending) begin
            view[POS_VALID] = 1'b0;
        end
        rd_byte = 8'h00;
        if (rd_idx == IDX_IND_CTRL) begin
            rd_byte = s.sel_code;
        end else if (rd_idx == IDX_IND_ADDR) begin
            rd_byte = s.idx_lo;
        end else if (rd_idx >= IDX_DATA_FIRST && rd_idx <= IDX_DATA_LAST) begin
            rd_byte = view[8'(IDX_DATA_LAST - rd_idx) * 8 +: 8];
        end else if (rd_idx == IDX_CFG) begin
            rd_byte = {6'h00, s.cfg};
        end else if (rd_idx == IDX_STATUS) begin
            rd_byte = {6'h00, s.mib_pending, s.tbl_pending};
        end
    end

    // Next state
    always_comb begin
        next_s = s;
        // One-cycle ack, dropped in the cycle after it was given
        next_s.ack   = bus_req && !s.ack;
        next_s.rdata = (bus_req && !s.ack) ? {24'h000000, rd_byte} : 32'h00000000;

        // Register writes; data registers ignore writes
        next_s.tbl_stage1 = 1'b0;
        next_s.tbl_stage2 = s.tbl_stage1;
        if (wr_take) begin
            if (wr_idx == IDX_IND_CTRL) begin
                next_s.sel_code = dat_i[7:0];
            end else if (wr_idx == IDX_CFG) begin
                next_s.cfg = dat_i[1:0];
            end else if (wr_idx == IDX_IND_ADDR) begin
                next_s.idx_lo = dat_i[7:0];
                if (s.sel_code[7:2] == SEL_TABLE_READ) begin
                    // Upper index bits come from the selection code
                    next_s.tbl_addr    = {s.sel_code[1:0], dat_i[7:0]};
                    next_s.tbl_pending = 1'b1;
                    next_s.tbl_stage1  = 1'b1;
                end else if (s.sel_code == SEL_STATS_READ) begin
                    next_s.mib_addr    = dat_i[7:0];
                    next_s.mib_pending = 1'b1;
                end
            end
        end

        // Table snapshot taken whole, two cycles after the trigger
        if (s.tbl_stage2) begin
            next_s.snap                          = '0;
            next_s.snap[POS_EMPTY]               = s.count == '0;
            next_s.snap[POS_CNT_LO +: 10]        = cnt_minus1[9:0];
            next_s.snap[POS_AGE_LO +: 2]         = table_q[59:58];
            next_s.snap[POS_PORT_LO +: 3]        = table_q[57:55];
            next_s.snap[POS_FID_LO +: FID_W]     = table_q[54:48];
            next_s.snap[MAC_W-1:0]               = table_q[MAC_W-1:0];
            next_s.tbl_pending                   = next_s.tbl_stage1;
        end

        // Counter updates; an event in the read cycle survives the clear
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int o = 0; o < NUM_STATS; o++) begin
                logic [CTR_W:0] base;
                logic [CTR_W:0] sum;
                logic [10:0]    amt;
                base = s.ctr[p*NUM_STATS + o];
                amt  = 11'd0;
                if (rx_inc[o] && rx_port_i == 3'(p)) begin
                    amt = (o == OFS_RX_LO_OCT || o == OFS_RX_HI_OCT) ? rx_len_i : 11'd1;
                end
                if (tx_inc[o] && tx_port_i == 3'(p)) begin
                    amt = (o == OFS_TX_LO_OCT || o == OFS_TX_HI_OCT) ? tx_len_i : 11'd1;
                end
                if (s.mib_pending && mib_hit && mib_sel == p*NUM_STATS + o) begin
                    base = '0;
                end
                sum = {1'b0, base[CTR_W-1:0]} + {20'h00000, amt};
                next_s.ctr[p*NUM_STATS + o] = {base[CTR_W] | sum[CTR_W],
                                               sum[CTR_W-1:0]};
            end
        end

        // Counter snapshot one cycle after the trigger
        if (s.mib_pending) begin
            next_s.snap = '0;
            if (mib_hit) begin
                next_s.snap[POS_OVERFLOW] = s.ctr[mib_sel][CTR_W];
                next_s.snap[CTR_W-1:0]    = s.ctr[mib_sel][CTR_W-1:0];
            end
            next_s.snap[POS_VALID]        = 1'b1;
            next_s.mib_pending            = 1'b0;
        end

        // Occupancy tracking from the learning engine
        if (learn_we_i && !s.valid_vec[learn_index_i]) begin
            next_s.valid_vec[learn_index_i] = 1'b1;
            next_s.count = s.count + 1'b1;
        end else if (!learn_we_i && learn_del_i && s.valid_vec[learn_index_i]) begin
            next_s.valid_vec[learn_index_i] = 1'b0;
            next_s.count = s.count - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s                  <= '0;
            s.sel_code         <= CTRL_RESET;
            s.cfg              <= CFG_RESET;
            s.snap[POS_EMPTY]  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign dat_o         = s.rdata;
    assign ack_o         = s.ack;
    assign table_count_o = s.count;

endmodule : switch_table_and_stats_readout

/* switch_readout_asserts.sv */
`timescale 1ns/1ns

// Bus answer and table occupancy checks, seen from the top-level pins only
module switch_readout_asserts
    import switch_readout_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               learn_we_i,
    input  wire logic               learn_del_i,
    input  wire logic [31:0]        dat_o,
    input  wire logic               ack_o,
    input  wire logic [COUNT_W-1:0] table_count_o
);
    default clocking main_cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_after_req_a: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("bus request not answered in the next cycle");
    ack_single_a: assert property (ack_o |=> !ack_o)
        else $error("acknowledge held longer than one cycle");
    ack_needs_req_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("acknowledge without a pending request");
    data_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data not zero outside acknowledge");
    data_byte_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("register data wider than one byte");
    count_reset_a: assert property ($past(rst_i) |-> table_count_o == 11'h0)
        else $error("entry count not cleared by reset");
    count_hold_a: assert property (!learn_we_i && !learn_del_i |=> $stable(table_count_o))
        else $error("entry count moved without learning activity");
    count_grow_a: assert property (learn_we_i |=> table_count_o >= $past(table_count_o))
        else $error("entry count fell on a learn write");
    count_limit_a: assert property (table_count_o <= 11'd1024)
        else $error("entry count beyond table depth");
endmodule : switch_readout_asserts

bind switch_table_and_stats_readout switch_readout_asserts switch_readout_asserts_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .learn_we_i(learn_we_i),
    .learn_del_i(learn_del_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .table_count_o(table_count_o)
);

/* host_wb_master.sv */
`timescale 1ns/1ns

// Host processor: classic bus master plus the indirect read sequences
module host_wb_master
    import switch_readout_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic      [9:0]  adr_o,
    output logic      [31:0] dat_o,
    output logic             we_o,
    output logic      [3:0]  sel_o,
    output logic             cyc_o,
    output logic             stb_o
);
    // Idle bus from time zero
    initial begin
        {adr_o, dat_o, we_o, sel_o, cyc_o, stb_o} = '0;
    end

    // One access held until ack; next call's edge gives the idle gap
    task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                          output logic [7:0] rd);
        @(posedge clk_i);
        adr_o <= {idx, 2'b00};
        dat_o <= {24'h0, wd};
        we_o  <= wr;
        sel_o <= 4'hf;
        {cyc_o, stb_o} <= 2'b11;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rd = dat_i[7:0];
        {cyc_o, stb_o, we_o} <= 3'b000;
    endtask : access

    // Selection code first, then the index byte that starts the read
    task automatic trigger(input logic [7:0] code, input logic [7:0] low);
        logic [7:0] rd;
        access(1'b1, IDX_IND_CTRL, code, rd);
        access(1'b1, IDX_IND_ADDR, low, rd);
    endtask : trigger

    // Reread the flag byte until it shows ready; the bench timeout ends a hang
    task automatic wait_ready(input logic [7:0] idx, input int pos, input logic ok,
                              output logic [7:0] rd);
        do access(1'b0, idx, 8'h00, rd); while (rd[pos] !== ok);
    endtask : wait_ready
endmodule : host_wb_master

/* switch_table_and_stats_readout_bench.sv */
`timescale 1ns/1ns

// Bench: host model on the bus, random frames, reference counters
module switch_table_and_stats_readout_bench
    import switch_readout_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, ack, we, cyc, stb;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic learn_we = 1'b0, learn_del = 1'b0, rx_done = 1'b0, tx_done = 1'b0, tx_late = 1'b0;
    logic [9:0] learn_index = '0;
    logic [47:0] learn_mac = '0;
    logic [6:0] filter_group_id = '0;
    logic [2:0] learn_port = '0, rx_port = '0, tx_port = '0;
    logic [1:0] learn_age = '0;
    logic [10:0] rx_len = '0, tx_len = '0;
    logic [7:0] rx_q = '0;
    logic [3:0] tx_q = '0;
    logic [COUNT_W-1:0] table_count;
    int ctr [NUM_PORTS][NUM_STATS];
    logic [60:0] entry_m [TABLE_DEPTH];
    bit valid_m [TABLE_DEPTH];
    int cnt = 0, errors = 0, samples_checked = 0;

    // Clock at 100 ns period
    always #50 clk_i = ~clk_i;

    host_wb_master host_wb_master_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
        .adr_o(adr), .dat_o(wdat), .we_o(we), .sel_o(sel), .cyc_o(cyc), .stb_o(stb));

    switch_table_and_stats_readout switch_table_and_stats_readout_inst (.clk_i(clk_i),
        .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .we_i(we), .sel_i(sel),
        .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .learn_we_i(learn_we), .learn_del_i(learn_del),
        .learn_index_i(learn_index), .learn_mac_i(learn_mac), .filter_group_id_i(filter_group_id),
        .learn_port_i(learn_port), .learn_age_i(learn_age), .rx_done_i(rx_done),
        .rx_port_i(rx_port), .rx_len_i(rx_len), .rx_high_prio_i(rx_q[7]),
        .rx_crc_ok_i(rx_q[6]), .rx_symbol_err_i(rx_q[5]), .rx_odd_bits_i(rx_q[4]),
        .rx_bcast_i(rx_q[3]), .rx_mcast_i(rx_q[2]), .rx_ctrl_type_i(rx_q[1]),
        .rx_pause_fields_i(rx_q[0]), .tx_done_i(tx_done), .tx_port_i(tx_port),
        .tx_len_i(tx_len), .tx_high_prio_i(tx_q[3]), .tx_good_i(tx_q[2]), .tx_pause_i(tx_q[1]),
        .tx_bcast_i(tx_q[0]), .tx_late_collide_i(tx_late), .table_count_o(table_count));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // Learning engine write or delete, mirrored in the reference table
    task automatic learn(input int idx, input bit del);
        logic [60:0] e;
        e = {2'($urandom), 3'($urandom_range(4)), 1'b0, 7'($urandom), 48'({$urandom, $urandom})};
        @(posedge clk_i);
        {learn_we, learn_del, learn_index} <= {!del, del, 10'(idx)};
        {learn_age, learn_port, filter_group_id, learn_mac} <= {e[60:56], e[54:0]};
        if (!del && !valid_m[idx]) cnt++;
        if (del && valid_m[idx]) cnt--;
        if (!del) entry_m[idx] = e;
        valid_m[idx] = !del;
        @(posedge clk_i);
        {learn_we, learn_del} <= 2'b00;
    endtask : learn

    // Table read; a learn after capture must not leak into the snapshot
    task automatic table_read(input int idx, input int nbytes);
        logic [7:0] rd;
        logic [71:0] want;
        want = {cnt == 0, 10'(cnt == 0 ? 0 : cnt - 1), entry_m[idx]};
        host_wb_master_inst.trigger({SEL_TABLE_READ, idx[9:8]}, idx[7:0]);
        host_wb_master_inst.wait_ready(8'd114, 7, 1'b0, rd);
        if (nbytes > 1) learn(5, 1'b0);
        for (int k = 0; k < nbytes; k++) begin
            host_wb_master_inst.access(1'b0, IDX_DATA_FIRST + 8'(k), 8'h00, rd);
            check($sformatf("entry byte %0d", k), {24'h0, rd}, {24'h0, want[71-8*k -: 8]});
        end
    endtask : table_read

    // Counter read, then the reference is cleared as the device clears its own
    task automatic stats_read(input int p, input int ofs);
        logic [7:0] rd;
        logic [31:0] v;
        host_wb_master_inst.trigger(SEL_STATS_READ, 8'(p * 32 + ofs));
        host_wb_master_inst.wait_ready(8'd117, 6, 1'b1, rd);
        v = {24'h0, rd};
        for (int k = 1; k < 4; k++) begin
            host_wb_master_inst.access(1'b0, 8'd117 + 8'(k), 8'h00, rd);
            v = {v[23:0], rd};
        end
        check($sformatf("port %0d counter %0h", p, ofs), v, {2'b01, 30'(ctr[p][ofs])});
        ctr[p][ofs] = 0;
    endtask : stats_read

    // One receive and one transmit frame; flag mixes kept unambiguous
    task automatic traffic();
        int p, q, l, n, lens [9];
        bit c, s, o, b, m, t, z, h, k, g, pa, bc, late;
        lens = '{40, 64, 100, 200, 300, 600, 1100, 1522, 1600};
        {p, q, l, n} = {$urandom_range(4), $urandom_range(4), lens[$urandom_range(8)], $urandom_range(64, 1522)};
        {c, h, k, b} = {$urandom_range(3) != 0, 1'($urandom), 1'($urandom), $urandom_range(3) == 0};
        {o, s} = {!c && 1'($urandom), c && l >= 64 && l <= 1522 && $urandom_range(4) == 0};
        {m, g, late} = {!b && 1'($urandom), $urandom_range(3) != 0, $urandom_range(4) == 0};
        {t, pa} = {m && 1'($urandom), g && $urandom_range(3) == 0};
        {z, bc} = {t && 1'($urandom), g && !pa && 1'($urandom)};
        ctr[p][h] += l;
        if (l < 64) ctr[p][c ? 2 : 3]++;
        else if (l > 1522) ctr[p][c ? 4 : 5]++;
        else begin
            if (s) ctr[p][6]++;
            if (!c) ctr[p][o ? 8 : 7]++;
            if (c && !s) ctr[p][b ? 11 : (m ? (t ? 0 : 12) : 13)] += (b || !m || !t) ? 1 : 0;
            ctr[p][l == 64 ? 14 : l < 128 ? 15 : l < 256 ? 16 : l < 512 ? 17 : l < 1024 ? 18 : 19]++;
        end
        if (t) ctr[p][9]++;
        if (t && z && l >= 64 && c && !s) ctr[p][10]++;
        if (g) ctr[q][20 + k] += n;
        ctr[q][22] += late;
        ctr[q][23] += pa;
        ctr[q][24] += bc;
        @(posedge clk_i);
        {rx_done, tx_done, tx_late, rx_port, tx_port} <= {2'b11, late, 3'(p), 3'(q)};
        {rx_len, tx_len, rx_q, tx_q} <= {11'(l), 11'(n), h, c, s, o, b, m, t, z, k, g, pa, bc};
        @(posedge clk_i);
        {rx_done, tx_done, tx_late} <= 3'b000;
    endtask : traffic

    // Main sequence
    initial begin
        logic [7:0] rd;
        void'($urandom(98587));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        table_read(0, 1);
        host_wb_master_inst.access(1'b0, 8'h90, 8'h00, rd);
        check("unmapped read", {24'h0, rd}, 32'h0);
        learn(257, 1'b0);
        learn(3, 1'b0);
        learn(3, 1'b1);
        learn(700, 1'b0);
        @(negedge clk_i);
        check("table count", 32'(table_count), 32'(cnt));
        table_read(257, 9);
        repeat (80) traffic();
        for (int p = 0; p < NUM_PORTS; p++)
            for (int o = 0; o < NUM_STATS; o++) stats_read(p, o);
        stats_read(0, 0);
        host_wb_master_inst.access(1'b1, IDX_CFG, 8'h03, rd);
        host_wb_master_inst.access(1'b0, IDX_CFG, 8'h00, rd);
        check("size config", {24'h0, rd}, 32'h3);
        print_verdict();
    end

    // Watchdog for a hung handshake
    initial begin
        repeat (30000) @(posedge clk_i);
        errors++;
        print_verdict();
    end
endmodule : switch_table_and_stats_readout_bench
